/* File: shared/pifb_defs.svh */
`ifndef PIFB_DEFS_SVH
`define PIFB_DEFS_SVH

// ------------------------------------------------------------
// Widths and counts
// ------------------------------------------------------------
`define PIFB_ADDR_W        12
`define PIFB_DATA_W        8
`define PIFB_NUM_PTIMERS   3
`define PIFB_NUM_OTIMERS   3
`define PIFB_NUM_LCELLS    4
`define PIFB_NUM_GATES     3
`define PIFB_NUM_CCP       5

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define PIFB_ADDR_TIMER    12'h710
`define PIFB_ADDR_LCELL    12'h711
`define PIFB_ADDR_CAPCOMP  12'h712
`define PIFB_ADDR_SUMMARY  12'h720
`define PIFB_ADDR_MASK     12'h721

// ------------------------------------------------------------
// Reset values and implemented bits
// ------------------------------------------------------------
`define PIFB_RESET_VAL     8'h00
`define PIFB_IMPL_TIMER    8'h3F
`define PIFB_IMPL_LCELL    8'hF7
`define PIFB_IMPL_CAPCOMP  8'h1F
`define PIFB_IMPL_SUMMARY  8'h07

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PIFB_T1_BIT        0
`define PIFB_T2_BIT        1
`define PIFB_T3_BIT        2
`define PIFB_T4_BIT        3
`define PIFB_T5_BIT        4
`define PIFB_T6_BIT        5
`define PIFB_LC_LSB        4
`define PIFB_GATE_LSB      0
`define PIFB_CC_LSB        0
`define PIFB_SUM_TIMER_BIT 0
`define PIFB_SUM_LCELL_BIT 1
`define PIFB_SUM_CC_BIT    2

`endif

/* File: shared/pifb_pkg.sv */
`default_nettype none
`include "pifb_defs.svh"

package pifb_pkg;

  typedef enum logic [1:0] {
    CCP_OFF     = 2'b00,
    CCP_CAPTURE = 2'b01,
    CCP_COMPARE = 2'b10,
    CCP_PWM     = 2'b11
  } pifb_ccp_mode_e;

  typedef struct packed {
    logic [`PIFB_ADDR_W-1:0] addr;
    logic [`PIFB_DATA_W-1:0] wdata;
    logic                    wr;
    logic                    rd;
  } pifb_bus_s;

  // Timers 2/4/6 (period type) and 1/3/5 (overflow type), index 0 first
  typedef struct packed {
    logic [`PIFB_NUM_PTIMERS-1:0] postOverflow;
    logic [`PIFB_NUM_PTIMERS-1:0] periodMatch;
    logic [`PIFB_NUM_PTIMERS-1:0] postOneToOne;
    logic [`PIFB_NUM_OTIMERS-1:0] counterOverflow;
  } pifb_timer_ev_s;

  typedef struct packed {
    pifb_ccp_mode_e [`PIFB_NUM_CCP-1:0] mode;
    logic [`PIFB_NUM_CCP-1:0]           capture;
    logic [`PIFB_NUM_CCP-1:0]           compareMatch;
    logic [`PIFB_NUM_CCP-1:0]           pwmOut;
  } pifb_ccp_ev_s;

endpackage : pifb_pkg

`default_nettype wire

/* File: rtl/pifb_fall_det.sv */
`timescale 1ns/100ps
`default_nettype none

module pifb_fall_det #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] fell
);

  logic [W-1:0] prevLevel;

  // Previous level resets low so no false edge follows reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevLevel <= '0;
    end else begin
      prevLevel <= level;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign fell[i] = prevLevel[i] & ~level[i];
    end
  endgenerate

endmodule : pifb_fall_det

`default_nettype wire

/* File: rtl/pifb_flag_reg.sv */
`timescale 1ns/100ps
`default_nettype none

module pifb_flag_reg #(
  parameter logic [7:0] IMPL  = 8'hFF,
  parameter logic [7:0] RESET = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       wrSel,
  input  wire logic [7:0] wdata,
  input  wire logic       rdClear,
  input  wire logic [7:0] set,
  output logic      [7:0] flags
);

  logic [7:0] next_flags;

  always_comb begin
    next_flags = flags;
    if (rdClear) begin
      next_flags = '0;
    end
    if (wrSel) begin
      next_flags = wdata & IMPL;
    end
    // Set is applied last so an event beats a same-cycle clear
    next_flags = (next_flags | set) & IMPL;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= RESET;
    end else begin
      flags <= next_flags;
    end
  end

endmodule : pifb_flag_reg

`default_nettype wire

/* File: rtl/pifb_flag_bank.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "pifb_defs.svh"

// Summary of operation
// - Timer-flag bit 5 sets on sixth timer postscaler overflow, or period match at 1:1.
// - Timer-flag bit 3 sets on fourth timer postscaler overflow, or period match at 1:1.
// - Timer-flag bit 1 sets on second timer postscaler overflow, or period match at 1:1.
// - Timer-flag bit 4 sets on fifth timer counter overflow, held until cleared.
// - Timer-flag bit 2 sets on third timer counter overflow, held until cleared.
// - Timer-flag bit 0 sets on first timer counter overflow, held until cleared.
// - Flags set on their event regardless of any enable bit.
// - Logic-cell flag register sits at 0x711 and resets to zero.
// - Bits 7..4 set on logic cells four..one output interrupt conditions.
// - Bits 2,1,0 set when gates of timers five, three, one go inactive.
// - Capture/compare flags at 0x712, channels five..one in bits 4..0, reset zero.
// - In capture mode a channel flag sets on each capture.
// - In compare mode a channel flag sets on each compare match.
// - In PWM mode a channel flag sets on each output trailing edge.
// - Timer flag register sits at 0x710, six flags in bits 5..0, reset zero.
module pifb_flag_bank
  import pifb_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire pifb_bus_s                   bus,
  output logic      [`PIFB_DATA_W-1:0]     rdata,
  input  wire pifb_timer_ev_s              timerEv,
  input  wire logic [`PIFB_NUM_LCELLS-1:0] logicCellIrq,
  input  wire logic [`PIFB_NUM_GATES-1:0]  gateActive,
  input  wire pifb_ccp_ev_s                ccpEv,
  output logic      [`PIFB_DATA_W-1:0]     timerEventFlags,
  output logic      [`PIFB_DATA_W-1:0]     logicCellAndGateFlags,
  output logic      [`PIFB_DATA_W-1:0]     captureCompareFlags,
  output logic                             irq
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic selTimer;
  logic selLcell;
  logic selCapcomp;
  logic selSummary;
  logic selMask;
  logic selAny;

  assign selTimer   = (bus.addr == `PIFB_ADDR_TIMER);
  assign selLcell   = (bus.addr == `PIFB_ADDR_LCELL);
  assign selCapcomp = (bus.addr == `PIFB_ADDR_CAPCOMP);
  assign selSummary = (bus.addr == `PIFB_ADDR_SUMMARY);
  assign selMask    = (bus.addr == `PIFB_ADDR_MASK);
  assign selAny     = selTimer | selLcell | selCapcomp | selSummary | selMask;

  logic wrTimer;
  logic wrLcell;
  logic wrCapcomp;
  logic wrMask;
  logic rdSummary;

  assign wrTimer   = bus.wr & selTimer;
  assign wrLcell   = bus.wr & selLcell;
  assign wrCapcomp = bus.wr & selCapcomp;
  assign wrMask    = bus.wr & selMask;
  assign rdSummary = bus.rd & selSummary;

  // ------------------------------------------------------------
  // Timer events
  // ------------------------------------------------------------
  logic [`PIFB_NUM_PTIMERS-1:0] periodEv;
  logic [`PIFB_DATA_W-1:0]      timerSet;

  // At 1:1 every match is an event; otherwise only postscaler rollover
  genvar t;
  generate
    for (t = 0; t < `PIFB_NUM_PTIMERS; t++) begin : g_ptimer
      assign periodEv[t] = timerEv.postOneToOne[t] ? timerEv.periodMatch[t]
                                                   : timerEv.postOverflow[t];
    end
  endgenerate

  always_comb begin
    timerSet = '0;
    timerSet[`PIFB_T1_BIT] = timerEv.counterOverflow[0];
    timerSet[`PIFB_T2_BIT] = periodEv[0];
    timerSet[`PIFB_T3_BIT] = timerEv.counterOverflow[1];
    timerSet[`PIFB_T4_BIT] = periodEv[1];
    timerSet[`PIFB_T5_BIT] = timerEv.counterOverflow[2];
    timerSet[`PIFB_T6_BIT] = periodEv[2];
  end

  // ------------------------------------------------------------
  // Logic cell and gate-done events
  // ------------------------------------------------------------
  logic [`PIFB_NUM_GATES-1:0] gateFell;
  logic [`PIFB_DATA_W-1:0]    lcellSet;

  // Gate completion is the active-to-inactive transition
  pifb_fall_det #(
    .W (`PIFB_NUM_GATES)
  ) u_gate_det (
    .clk     (clk),
    .reset_n (reset_n),
    .level   (gateActive),
    .fell    (gateFell)
  );

  always_comb begin
    lcellSet = '0;
    lcellSet[`PIFB_LC_LSB +: `PIFB_NUM_LCELLS]   = logicCellIrq;
    lcellSet[`PIFB_GATE_LSB +: `PIFB_NUM_GATES]  = gateFell;
  end

  // ------------------------------------------------------------
  // Capture/compare/PWM events
  // ------------------------------------------------------------
  logic [`PIFB_NUM_CCP-1:0] pwmFell;
  logic [`PIFB_NUM_CCP-1:0] ccpHit;
  logic [`PIFB_DATA_W-1:0]  ccSet;

  // Edge is tracked in every mode so a mode switch to PWM sees clean history
  pifb_fall_det #(
    .W (`PIFB_NUM_CCP)
  ) u_pwm_det (
    .clk     (clk),
    .reset_n (reset_n),
    .level   (ccpEv.pwmOut),
    .fell    (pwmFell)
  );

  genvar c;
  generate
    for (c = 0; c < `PIFB_NUM_CCP; c++) begin : g_ccp
      always_comb begin
        case (ccpEv.mode[c])
          CCP_CAPTURE: begin
            ccpHit[c] = ccpEv.capture[c];
          end
          CCP_COMPARE: begin
            ccpHit[c] = ccpEv.compareMatch[c];
          end
          CCP_PWM: begin
            ccpHit[c] = pwmFell[c];
          end
          default: begin
            ccpHit[c] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  always_comb begin
    ccSet = '0;
    ccSet[`PIFB_CC_LSB +: `PIFB_NUM_CCP] = ccpHit;
  end

  // ------------------------------------------------------------
  // Flag registers
  // ------------------------------------------------------------
  // No enable input reaches the set paths: flags latch unconditionally
  pifb_flag_reg #(
    .IMPL  (`PIFB_IMPL_TIMER),
    .RESET (`PIFB_RESET_VAL)
  ) u_timer_flags (
    .clk     (clk),
    .reset_n (reset_n),
    .wrSel   (wrTimer),
    .wdata   (bus.wdata),
    .rdClear (1'b0),
    .set     (timerSet),
    .flags   (timerEventFlags)
  );

  pifb_flag_reg #(
    .IMPL  (`PIFB_IMPL_LCELL),
    .RESET (`PIFB_RESET_VAL)
  ) u_lcell_flags (
    .clk     (clk),
    .reset_n (reset_n),
    .wrSel   (wrLcell),
    .wdata   (bus.wdata),
    .rdClear (1'b0),
    .set     (lcellSet),
    .flags   (logicCellAndGateFlags)
  );

  pifb_flag_reg #(
    .IMPL  (`PIFB_IMPL_CAPCOMP),
    .RESET (`PIFB_RESET_VAL)
  ) u_cc_flags (
    .clk     (clk),
    .reset_n (reset_n),
    .wrSel   (wrCapcomp),
    .wdata   (bus.wdata),
    .rdClear (1'b0),
    .set     (ccSet),
    .flags   (captureCompareFlags)
  );

  // ------------------------------------------------------------
  // Interrupt summary, mask and output
  // ------------------------------------------------------------
  logic [`PIFB_DATA_W-1:0] sumSet;
  logic [`PIFB_DATA_W-1:0] summary;
  logic [`PIFB_DATA_W-1:0] mask;

  always_comb begin
    sumSet = '0;
    sumSet[`PIFB_SUM_TIMER_BIT] = |timerSet;
    sumSet[`PIFB_SUM_LCELL_BIT] = |lcellSet;
    sumSet[`PIFB_SUM_CC_BIT]    = |ccSet;
  end

  // Read-to-clear; a new event in the reading cycle survives
  pifb_flag_reg #(
    .IMPL  (`PIFB_IMPL_SUMMARY),
    .RESET (`PIFB_RESET_VAL)
  ) u_summary (
    .clk     (clk),
    .reset_n (reset_n),
    .wrSel   (1'b0),
    .wdata   (bus.wdata),
    .rdClear (rdSummary),
    .set     (sumSet),
    .flags   (summary)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask <= `PIFB_RESET_VAL;
    end else if (wrMask) begin
      mask <= bus.wdata & `PIFB_IMPL_SUMMARY;
    end
  end

  assign irq = |(summary & mask);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [`PIFB_DATA_W-1:0] next_rdata;

  // Unmapped addresses read zero; data stands only one cycle
  always_comb begin
    next_rdata = '0;
    if (bus.rd && selAny) begin
      if (selTimer) begin
        next_rdata = timerEventFlags;
      end else if (selLcell) begin
        next_rdata = logicCellAndGateFlags;
      end else if (selCapcomp) begin
        next_rdata = captureCompareFlags;
      end else if (selSummary) begin
        next_rdata = summary;
      end else begin
        next_rdata = mask;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule : pifb_flag_bank

`default_nettype wire

/* File: tb/pifb_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module pifb_checker
  import pifb_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset_n,
  input wire pifb_bus_s      bus,
  input wire logic [7:0]     rdata,
  input wire pifb_timer_ev_s timerEv,
  input wire logic [3:0]     logicCellIrq,
  input wire logic [2:0]     gateActive,
  input wire pifb_ccp_ev_s   ccpEv,
  input wire logic [7:0]     timerEventFlags,
  input wire logic [7:0]     logicCellAndGateFlags,
  input wire logic [7:0]     captureCompareFlags,
  input wire logic           irq
);
  // --------
  // Properties
  // --------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_ovf1;
    timerEv.counterOverflow[0] |=> timerEventFlags[0];
  endproperty
  a_ovf1: assert property (p_ovf1) else $error("timer1 flag missed");
  property p_ovf5;
    timerEv.counterOverflow[2] |=> timerEventFlags[4];
  endproperty
  a_ovf5: assert property (p_ovf5) else $error("timer5 flag missed");
  property p_per2;
    (timerEv.postOneToOne[0] ? timerEv.periodMatch[0] : timerEv.postOverflow[0]) |=> timerEventFlags[1];
  endproperty
  a_per2: assert property (p_per2) else $error("timer2 flag missed");
  property p_lc4;
    logicCellIrq[3] |=> logicCellAndGateFlags[7];
  endproperty
  a_lc4: assert property (p_lc4) else $error("cell4 flag missed");
  property p_gate1;
    $fell(gateActive[0]) |=> logicCellAndGateFlags[0];
  endproperty
  a_gate1: assert property (p_gate1) else $error("gate1 flag missed");
  property p_cap1;
    ccpEv.capture[0] && ccpEv.mode[0] == CCP_CAPTURE |=> captureCompareFlags[0];
  endproperty
  a_cap1: assert property (p_cap1) else $error("capture flag missed");
  property p_rsv;
    timerEventFlags[7:6] == 2'h0 && !logicCellAndGateFlags[3] && captureCompareFlags[7:5] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_rd;
    bus.rd && bus.addr == 12'h710 |=> rdata == $past(timerEventFlags);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read data");
endmodule : pifb_checker

bind pifb_flag_bank pifb_checker u_chk (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .timerEv(timerEv), .logicCellIrq(logicCellIrq), .gateActive(gateActive), .ccpEv(ccpEv),
  .timerEventFlags(timerEventFlags), .logicCellAndGateFlags(logicCellAndGateFlags),
  .captureCompareFlags(captureCompareFlags), .irq(irq));

`default_nettype wire

/* File: tb/pifb_event_src.sv */
`timescale 1ns/100ps
`default_nettype none

module pifb_event_src
  import pifb_pkg::*;
(
  input  wire logic [0:0]     clk,
  input  wire logic [2:0]     oneToOne,
  input  wire logic [9:0]     modeBits,
  output var pifb_timer_ev_s  timerEv,
  output logic      [3:0]     cellIrq,
  output logic      [2:0]     gateActive,
  output var pifb_ccp_ev_s    ccpEv
);
  // --------
  // Event lines
  // --------
  logic [30:0] ev;

  // All sources idle low between events
  initial ev = '0;

  always_comb begin
    timerEv = {ev[5:3], ev[8:6], oneToOne, ev[2:0]};
    cellIrq = ev[12:9];
    gateActive = ev[15:13];
    ccpEv = {modeBits, ev[20:16], ev[25:21], ev[30:26]};
  end

  // Level sources rise for one cycle, so the fall marks the event
  task automatic fire(input int s, input int k);
    int n;
    n = s < 3 ? s : s < 6 ? 3 * k + s : s < 13 ? s + 3 : 5 * k + s + 3;
    @(posedge clk);
    ev[n] <= 1'b1;
    @(posedge clk);
    ev[n] <= 1'b0;
  endtask : fire
endmodule : pifb_event_src

`default_nettype wire

/* File: tb/peripheral_interrupt_flag_bank_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module peripheral_interrupt_flag_bank_tb import pifb_pkg::*;;
  // --------
  // Bench
  // --------
  logic           clk;
  logic           reset_n;
  pifb_bus_s      bus;
  logic [7:0]     rdata;
  logic [7:0]     got;
  logic [7:0]     timerFlags;
  logic [7:0]     cellFlags;
  logic [7:0]     ccFlags;
  logic [2:0]     oneToOne;
  logic [9:0]     modeBits;
  pifb_timer_ev_s timerEv;
  logic [3:0]     cellIrq;
  logic [2:0]     gateActive;
  pifb_ccp_ev_s   ccpEv;
  logic           irq;
  logic [19:0]    ex;
  int             failures;
  int             compares;
  int             src;
  int             kind;
  logic [11:0]    regA [4] = '{12'h710, 12'h711, 12'h712, 12'h7FF};
  logic [7:0]     impl [4] = '{8'h3F, 8'hF7, 8'h1F, 8'h00};

  pifb_flag_bank uut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .timerEv(timerEv),
    .logicCellIrq(cellIrq), .gateActive(gateActive), .ccpEv(ccpEv), .timerEventFlags(timerFlags),
    .logicCellAndGateFlags(cellFlags), .captureCompareFlags(ccFlags), .irq(irq));
  pifb_event_src src_model (.clk(clk), .oneToOne(oneToOne), .modeBits(modeBits),
    .timerEv(timerEv), .cellIrq(cellIrq), .gateActive(gateActive), .ccpEv(ccpEv));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 got = rdata;
  endtask : rd

  function automatic logic [19:0] expect_of(int s, int k, logic [2:0] o, logic [9:0] m);
    if (s < 3) return {12'h710, 8'h01 << (2 * s)};
    if (s < 6) return {12'h710, ((o[s-3] ? k == 1 : k == 0) ? 8'h02 << (2 * s - 6) : 8'h00)};
    if (s < 10) return {12'h711, 8'h10 << (s - 6)};
    if (s < 13) return {12'h711, 8'h01 << (s - 10)};
    return {12'h712, (int'(m[2*(s-13)+:2]) == k + 1) ? 8'h01 << (s - 13) : 8'h00};
  endfunction : expect_of

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Whole run needs about 1400 cycles; allow 20000
  initial begin
    #(20 * 20000);
    failures++;
    wrap_up();
  end

  initial begin
    bus = '0;
    oneToOne = '0;
    modeBits = '0;
    reset_n = 1'b0;
    failures = 0;
    compares = 0;
    src = $urandom(15);
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(regA[i]);
      check(got, 8'h00);
      wr(regA[i], 8'hFF);
      rd(regA[i]);
      check(got, impl[i]);
      wr(regA[i], 8'h00);
    end
    rd(12'h720);
    wr(12'h721, 8'h01);
    src_model.fire(0, 0);
    repeat (2) @(posedge clk);
    check({7'h00, irq}, 8'h01);
    rd(12'h720);
    check(got, 8'h01);
    check({7'h00, irq}, 8'h00);
    wr(12'h721, 8'h00);
    src_model.fire(0, 0);
    repeat (2) @(posedge clk);
    check({7'h00, irq}, 8'h00);
    rd(12'h720);
    check(got, 8'h01);
    wr(12'h710, 8'h00);
    fork
      src_model.fire(0, 0);
      wr(12'h710, 8'h00);
    join
    rd(12'h710);
    check(got, 8'h01);
    // First pass sweeps every source with matching channel modes
    for (int i = 0; i < 78; i++) begin
      src = i < 18 ? i : $urandom % 18;
      kind = (i < 18 ? i + 2 : $urandom) % (src < 13 ? 2 : 3);
      @(posedge clk);
      oneToOne <= 3'($urandom);
      modeBits <= i < 18 ? {5{2'(kind + 1)}} : 10'($urandom);
      for (int j = 0; j < 3; j++) wr(regA[j], 8'h00);
      rd(12'h720);
      src_model.fire(src, kind);
      repeat (2) @(posedge clk);
      ex = expect_of(src, kind, oneToOne, modeBits);
      rd(ex[19:8]);
      check(got, ex[7:0]);
      check(ex[9:8] == 2'h0 ? timerFlags : ex[9:8] == 2'h1 ? cellFlags : ccFlags, ex[7:0]);
      rd(12'h720);
      check(got, ex[7:0] != 8'h00 ? 8'h01 << ex[9:8] : 8'h00);
    end
    wrap_up();
  end
endmodule : peripheral_interrupt_flag_bank_tb

`default_nettype wire
